// [verilog/spc_sleep_ctrl.sv]
// sleep-mode power controller: sleep entry, clock gating, wake-up
// sequencing and software brown-out disable
// assumes the core gives a one-cycle sleep pulse and honours core_halt
// Functional notes
// - sleep needs enable bit plus instruction
// - three-bit select picks the sleep state
// - mode codes; standby needs external clock
// - each mode gates its own clock set
// - wake sources allowed per mode table
// - outside idle, dedicated irqs wake on level
// - serial wakes only via start frame
// - async timer wake needs asynchronous clocking; idle wakes on the timer without it
// - brown-out disable only in deep modes
// - four halt cycles after start-up, then service
// - register file and memory kept across sleep
// - reset in sleep restarts from reset vector
// - brown-out disable matters only when fused on
// - detector off as soon as sleep entered
// - wake-up re-enables the brown-out detector
// - about 60 us wake when detector was off
// - brown-out sleep bit one disables, resets zero
// - timed enable sequence guards that bit
// - standby modes wake in six cycles
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module spc_sleep_ctrl
    import spc_pkg::*;
#(
    parameter int STARTUP_CYC = 16
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // core side
    input  wire logic       sleep_instr,
    output logic            core_halt,
    output logic            irq_service,
    output logic            sleeping,
    // straps and pins
    input  wire logic       ext_clock_option,
    input  wire logic       bod_fuse_enable,
    input  wire logic [1:0] ext_irq_level_n,
    input  wire logic       async_timer_async,
    // wake events from on-chip logic
    input  spc_wake_t       wake_evt,
    // power outputs
    output spc_gate_t       clk_gate,
    output logic            bod_enable
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        spc_state_t           state;
        logic                 sleep_enable_bit;
        logic [2:0]           sleep_mode_select;
        logic [2:0]           mode;
        logic                 brownout_sleep_bit;
        logic [2:0]           bsb_window;
        logic                 bod_off;
        logic [SPC_CNT_W-1:0] cnt;
        logic [7:0]           rdata;
    } spc_regs_t;

    spc_regs_t r;
    spc_regs_t next_r;

    logic [2:0] pin_sync;
    logic       ext_clk_ok;
    logic [1:0] ext_level;
    logic       wake;
    logic       deep_mode;
    logic       mode_ok;

    spc_sync #(.WIDTH(3)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     ({ext_clock_option, ~ext_irq_level_n}),
        .dout    (pin_sync)
    );
    assign ext_clk_ok = pin_sync[2];
    assign ext_level  = pin_sync[1:0];

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic spc_gate_t gate_f(input logic [2:0] m, input logic as_t);
        spc_gate_t g;
        g = '0;
        case (m)
            SPC_MODE_IDLE:
            begin
                g = '1;
                g.core_clk_en  = 1'b0;
                g.flash_clk_en = 1'b0;
            end
            SPC_MODE_NOISE:
            begin
                g.converter_clk_en = 1'b1;
                g.async_clk_en     = 1'b1;
                g.touch_clk_en     = 1'b1;
                g.main_osc_en      = 1'b1;
                g.timer_osc_en     = as_t;
            end
            SPC_MODE_PSAVE:
            begin
                g.async_clk_en = as_t;
                g.touch_clk_en = 1'b1;
                g.timer_osc_en = as_t;
            end
            SPC_MODE_STBY:
                g.main_osc_en = 1'b1;
            SPC_MODE_XSTBY:
            begin
                g.async_clk_en = as_t;
                g.touch_clk_en = 1'b1;
                g.main_osc_en  = 1'b1;
                g.timer_osc_en = as_t;
            end
            default:
                g = '0;
        endcase
        return g;
    endfunction

    function automatic logic deep_f(input logic [2:0] m);
        return (m == SPC_MODE_PDOWN) || (m == SPC_MODE_PSAVE) ||
               (m == SPC_MODE_STBY)  || (m == SPC_MODE_XSTBY);
    endfunction

    // ------------------------------------------------------------
    // wake decision
    // ------------------------------------------------------------
    always_comb
    begin
        logic idle_like;
        logic timer_ok;
        idle_like = (r.mode == SPC_MODE_IDLE) || (r.mode == SPC_MODE_NOISE);
        timer_ok  = (r.mode != SPC_MODE_PDOWN) && (r.mode != SPC_MODE_STBY);
        wake = (|ext_level) || wake_evt.pin_change_irq ||
               wake_evt.two_wire_match || wake_evt.watchdog_irq ||
               wake_evt.serial_start_frame;
        if (r.mode == SPC_MODE_IDLE)
            wake = wake || (|wake_evt.ext_irq_edge) || wake_evt.other_io_irq;
        if (timer_ok && (async_timer_async || r.mode == SPC_MODE_IDLE))
            wake = wake || wake_evt.async_timer_irq;
        if (idle_like)
            wake = wake || wake_evt.self_program_ready || wake_evt.converter_done;
    end

    assign deep_mode = deep_f(r.mode);
    // reserved codes and standby without an external clock do not sleep
    assign mode_ok = (r.sleep_mode_select == SPC_MODE_IDLE)  ||
                     (r.sleep_mode_select == SPC_MODE_NOISE) ||
                     (r.sleep_mode_select == SPC_MODE_PDOWN) ||
                     (r.sleep_mode_select == SPC_MODE_PSAVE) ||
                     (deep_f(r.sleep_mode_select) && ext_clk_ok);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r       = r;
        next_r.rdata = 8'h00;
        if (r.bsb_window != 3'h0)
            next_r.bsb_window = r.bsb_window - 3'h1;

        // register writes
        if (reg_wr && reg_addr == SPC_SLEEP_CTRL_OFS)
        begin
            next_r.sleep_enable_bit  = reg_wdata[SPC_SE_BIT];
            next_r.sleep_mode_select = reg_wdata[SPC_SM_LSB +: 3];
        end
        if (reg_wr && reg_addr == SPC_CORE_CTRL_OFS)
        begin
            if (reg_wdata[SPC_BSB_EN_BIT] && reg_wdata[SPC_BSB_BIT])
            begin
                if (r.bsb_window == 3'h0)
                    next_r.bsb_window = 3'(SPC_BSB_WINDOW_CYC);
            end
            else if (!reg_wdata[SPC_BSB_EN_BIT] && r.bsb_window != 3'h0)
            begin
                next_r.brownout_sleep_bit = reg_wdata[SPC_BSB_BIT];
                next_r.bsb_window         = 3'h0;
            end
        end

        case (r.state)
            SPC_ST_ACTIVE:
                // enable clear or an unusable code leaves the core running
                if (sleep_instr && r.sleep_enable_bit && mode_ok)
                begin
                    next_r.state = SPC_ST_SLEEP;
                    next_r.mode  = r.sleep_mode_select;
                    next_r.bod_off = r.brownout_sleep_bit && bod_fuse_enable &&
                                     deep_f(r.sleep_mode_select);
                end
            SPC_ST_SLEEP:
                if (wake)
                begin
                    next_r.state = SPC_ST_STARTUP;
                    if (r.bod_off)
                        next_r.cnt = SPC_CNT_W'(SPC_BOD_WAKE_CYC - 1);
                    else if (r.mode == SPC_MODE_STBY || r.mode == SPC_MODE_XSTBY)
                        next_r.cnt = SPC_CNT_W'(SPC_STBY_WAKE_CYC - 1);
                    else
                        next_r.cnt = SPC_CNT_W'(STARTUP_CYC - 1);
                end
            SPC_ST_STARTUP:
                if (r.cnt == '0)
                begin
                    next_r.state = SPC_ST_HALT;
                    next_r.cnt   = SPC_CNT_W'(SPC_HALT_CYC - 1);
                    next_r.bod_off = 1'b0;
                    next_r.brownout_sleep_bit = 1'b0;
                end
                else
                    next_r.cnt = r.cnt - 1'b1;
            SPC_ST_HALT:
                if (r.cnt == '0)
                    next_r.state = SPC_ST_SERVICE;
                else
                    next_r.cnt = r.cnt - 1'b1;
            SPC_ST_SERVICE:
                next_r.state = SPC_ST_ACTIVE;
            default:
                next_r.state = SPC_ST_ACTIVE;
        endcase

        // register reads, answered in the next cycle
        if (reg_rd)
        begin
            case (reg_addr)
                SPC_SLEEP_CTRL_OFS:
                    next_r.rdata = {4'h0, r.sleep_mode_select, r.sleep_enable_bit};
                SPC_CORE_CTRL_OFS:
                    next_r.rdata = {1'b0, r.brownout_sleep_bit,
                                    (r.bsb_window != 3'h0), 5'h00};
                SPC_STATUS_OFS:
                    next_r.rdata = {3'h0, bod_enable, sleeping, r.state};
                default:
                    next_r.rdata = 8'h00;
            endcase
        end
    end

    // a reset in any state lands in active; the core restarts at its vector
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r                    <= '0;
            r.state              <= SPC_ST_ACTIVE;
            r.sleep_enable_bit   <= SPC_SE_RST;
            r.sleep_mode_select  <= SPC_SM_RST;
            r.brownout_sleep_bit <= SPC_BSB_RST;
        end
        else
            r <= next_r;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // halting rather than resetting the core keeps its registers and memory
    assign core_halt   = (r.state != SPC_ST_ACTIVE);
    assign sleeping    = (r.state == SPC_ST_SLEEP);
    assign irq_service = (r.state == SPC_ST_SERVICE);
    assign reg_rdata   = r.rdata;
    assign bod_enable  = bod_fuse_enable && !(r.bod_off &&
                         (sleeping || r.state == SPC_ST_STARTUP));
    always_comb
    begin
        clk_gate = '1;
        if (sleeping)
            clk_gate = gate_f(r.mode, async_timer_async);
        else if (r.state == SPC_ST_STARTUP)
        begin
            clk_gate             = gate_f(r.mode, async_timer_async);
            clk_gate.main_osc_en = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_halt4;
        (r.state == SPC_ST_HALT) [*4] ##1 irq_service;
    endsequence
    sequence s_stby_wake;
        (r.state == SPC_ST_STARTUP) [*6] ##1 (r.state == SPC_ST_HALT);
    endsequence

    AST_ENTER: assert property (@(posedge clk) disable iff (!reset_n)
        (r.state == SPC_ST_ACTIVE && sleep_instr && r.sleep_enable_bit && mode_ok)
        |=> sleeping && r.mode == $past(r.sleep_mode_select))
        else $error("sleep not entered");
    AST_NOP: assert property (@(posedge clk) disable iff (!reset_n)
        (r.state == SPC_ST_ACTIVE && sleep_instr && !r.sleep_enable_bit)
        |=> !core_halt && clk_gate == '1)
        else $error("sleep without enable halted core");
    AST_IDLE_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        (sleeping && r.mode == SPC_MODE_IDLE)
        |-> !clk_gate.core_clk_en && !clk_gate.flash_clk_en && clk_gate.io_clk_en)
        else $error("idle gating wrong");
    AST_PDOWN_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        (sleeping && r.mode == SPC_MODE_PDOWN) |-> clk_gate == '0)
        else $error("power-down left a clock on");
    AST_HALT4: assert property (@(posedge clk) disable iff (!reset_n)
        (r.state == SPC_ST_STARTUP && r.cnt == '0) |=> s_halt4)
        else $error("halt length not four");
    AST_STBY6: assert property (@(posedge clk) disable iff (!reset_n)
        (sleeping && wake && !r.bod_off && r.mode == SPC_MODE_STBY) |=> s_stby_wake)
        else $error("standby wake not six cycles");
    AST_BOD_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        (sleeping && r.bod_off) |-> !bod_enable)
        else $error("detector on while disabled in sleep");
    AST_BOD_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        (sleeping && !deep_mode && bod_fuse_enable) |-> bod_enable)
        else $error("detector off in shallow mode");
    AST_BOD_BACK: assert property (@(posedge clk) disable iff (!reset_n)
        (r.state == SPC_ST_HALT && bod_fuse_enable) |-> bod_enable && !r.brownout_sleep_bit)
        else $error("detector not restored on wake");
    AST_GUARD: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_wr && reg_addr == SPC_CORE_CTRL_OFS && r.bsb_window == 3'h0 &&
         r.state == SPC_ST_ACTIVE) |=> $stable(r.brownout_sleep_bit))
        else $error("unguarded brown-out bit write");
endmodule

// [verilog/spc_pkg.sv]
// sleep-mode power controller: shared constants and carrier types
// assumes a single 50 MHz system clock and an 8-bit register port
package spc_pkg;

    // ------------------------------------------------------------
    // register map and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] SPC_SLEEP_CTRL_OFS  = 8'h00;
    localparam logic [7:0] SPC_CORE_CTRL_OFS   = 8'h01;
    localparam logic [7:0] SPC_STATUS_OFS      = 8'h02;
    localparam int         SPC_SE_BIT          = 0;
    localparam int         SPC_SM_LSB          = 1;
    localparam int         SPC_BSB_BIT         = 6;
    localparam int         SPC_BSB_EN_BIT      = 5;
    localparam logic       SPC_SE_RST          = 1'b0;
    localparam logic [2:0] SPC_SM_RST          = 3'h0;
    localparam logic       SPC_BSB_RST         = 1'b0;

    // ------------------------------------------------------------
    // sleep mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] SPC_MODE_IDLE       = 3'h0;
    localparam logic [2:0] SPC_MODE_NOISE      = 3'h1;
    localparam logic [2:0] SPC_MODE_PDOWN      = 3'h2;
    localparam logic [2:0] SPC_MODE_PSAVE      = 3'h3;
    localparam logic [2:0] SPC_MODE_STBY       = 3'h6;
    localparam logic [2:0] SPC_MODE_XSTBY      = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SPC_CLK_PERIOD_PS   = 20000;
    localparam int SPC_BOD_WAKE_US     = 60;
    localparam int SPC_BOD_WAKE_CYC    =
        (SPC_BOD_WAKE_US * 1000000 + SPC_CLK_PERIOD_PS - 1) / SPC_CLK_PERIOD_PS;
    localparam int SPC_STBY_WAKE_CYC   = 6;
    localparam int SPC_HALT_CYC        = 4;
    localparam int SPC_BSB_WINDOW_CYC  = 4;
    localparam int SPC_CNT_W           = 12;

    typedef enum logic [2:0] {
        SPC_ST_ACTIVE  = 3'b000,
        SPC_ST_SLEEP   = 3'b001,
        SPC_ST_STARTUP = 3'b010,
        SPC_ST_HALT    = 3'b011,
        SPC_ST_SERVICE = 3'b100
    } spc_state_t;

    typedef struct packed {
        logic core_clk_en;
        logic flash_clk_en;
        logic io_clk_en;
        logic converter_clk_en;
        logic async_clk_en;
        logic touch_clk_en;
        logic main_osc_en;
        logic timer_osc_en;
    } spc_gate_t;

    typedef struct packed {
        logic [1:0] ext_irq_edge;
        logic       pin_change_irq;
        logic       two_wire_match;
        logic       watchdog_irq;
        logic       serial_start_frame;
        logic       async_timer_irq;
        logic       self_program_ready;
        logic       converter_done;
        logic       other_io_irq;
    } spc_wake_t;

endpackage

// [verilog/spc_sync.sv]
// two-stage synchroniser for pin-level inputs
// assumes inputs are quasi-static relative to the system clock
`timescale 1ns/1ps
module spc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    meta[g] <= 1'b0;
                    dout[g] <= 1'b0;
                end
                else
                begin
                    meta[g] <= din[g];
                    dout[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule

// [bench/spc_core_model.sv]
// core model: issues one sleep pulse per bench request and counts services
// assumes the controller samples sleep_instr on the rising clock edge
`timescale 1ns/1ps
module spc_core_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // bench side
    input  wire logic go,
    output int        services,
    // controller side
    output logic      sleep_instr,
    input  wire logic core_halt,
    input  wire logic irq_service
);
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sleep_instr <= 1'b0;
            services    <= 0;
        end
        else
        begin
            // a halted core executes nothing, so no sleep pulse then
            sleep_instr <= go && !core_halt;
            if (irq_service)
                services <= services + 1;
        end
    end
endmodule

// [bench/sleep_mode_power_controller_tb_top.sv]
// bench for the sleep-mode power controller: register tasks and mode scenarios
// assumes STARTUP_CYC set to 3 and a 50 MHz clock
`timescale 1ns/1ps
module sleep_mode_power_controller_tb_top
    import spc_pkg::*;
;
    logic       clk              = 1'b0;
    logic       reset_n          = 1'b0;
    logic [7:0] reg_addr         = 8'h00;
    logic [7:0] reg_wdata        = 8'h00;
    logic       reg_wr           = 1'b0;
    logic       reg_rd           = 1'b0;
    logic       ext_clock_option = 1'b1;
    logic       bod_fuse_enable  = 1'b1;
    logic [1:0] ext_irq_level_n  = 2'h3;
    logic       async_timer_async = 1'b1;
    logic       go               = 1'b0;
    spc_wake_t  wake_evt         = '0;
    logic [7:0] reg_rdata;
    logic       sleep_instr;
    logic       core_halt;
    logic       irq_service;
    logic       sleeping;
    logic       bod_enable;
    spc_gate_t  clk_gate;
    int         services;
    int         err_total = 0;
    int         checks    = 0;
    int         cyc       = 0;
    // ------------------------------------------------------------
    // per-mode expectations
    // ------------------------------------------------------------
    logic [2:0] mode_tab [6] = '{SPC_MODE_IDLE, SPC_MODE_NOISE, SPC_MODE_PDOWN,
                                 SPC_MODE_PSAVE, SPC_MODE_STBY, SPC_MODE_XSTBY};
    logic [7:0] gate_tab [6] = '{8'h3F, 8'h1F, 8'h00, 8'h0D, 8'h02, 8'h0F};
    // a different wake source per mode: other io, converter, two-wire, timer, serial, pin
    logic [9:0] wake_tab [6] = '{10'h001, 10'h002, 10'h040, 10'h008, 10'h010, 10'h080};
    // edges after the one that takes the wake: start-up, then four halt cycles
    int         lat_tab  [6] = '{7, 7, 7, 7, 10, 10};

    always #10 clk = ~clk;

    spc_sleep_ctrl #(.STARTUP_CYC(3)) dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_instr(sleep_instr), .core_halt(core_halt), .irq_service(irq_service),
        .sleeping(sleeping), .ext_clock_option(ext_clock_option),
        .bod_fuse_enable(bod_fuse_enable), .ext_irq_level_n(ext_irq_level_n),
        .async_timer_async(async_timer_async), .wake_evt(wake_evt),
        .clk_gate(clk_gate), .bod_enable(bod_enable));

    spc_core_model core (
        .clk(clk), .reset_n(reset_n), .go(go), .services(services),
        .sleep_instr(sleep_instr), .core_halt(core_halt), .irq_service(irq_service));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(name, reg_rdata, exp);
    endtask

    task automatic slp(input logic [2:0] m, input logic se);
        wr(SPC_SLEEP_CTRL_OFS, {4'h0, m, se});
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // pulse one wake source, then count edges until the service pulse
    task automatic wake_time(input logic [9:0] src, input int lat);
        int n = 0;
        @(posedge clk);
        wake_evt <= src;
        @(posedge clk);
        wake_evt <= '0;
        while (irq_service !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            n++;
            #1;
        end
        chk("wake latency", n, lat);
        @(posedge clk);
        #1;
        chk("gates after wake", clk_gate, 8'hFF);
        chk("halt after wake", core_halt, 1'b0);
    endtask

    // ------------------------------------------------------------
    // hang guard and main sequence
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish;
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("gates at reset", clk_gate, 8'hFF);
        rd(SPC_SLEEP_CTRL_OFS, 8'h00, "sleep ctrl reset");
        rd(SPC_CORE_CTRL_OFS, 8'h00, "core ctrl reset");
        rd(SPC_STATUS_OFS, 8'h10, "status reset");
        rd(8'h07, 8'h00, "unmapped");
        $display("test reset done");

        slp(SPC_MODE_PDOWN, 1'b0);
        chk("enable clear", sleeping, 1'b0);
        slp(3'h4, 1'b1);
        chk("code 100", sleeping, 1'b0);
        slp(3'h5, 1'b1);
        chk("code 101", sleeping, 1'b0);
        ext_clock_option <= 1'b0;
        slp(SPC_MODE_STBY, 1'b1);
        chk("standby no ext clock", sleeping, 1'b0);
        ext_clock_option <= 1'b1;
        $display("test refusals done");

        for (int i = 0; i < 6; i++)
        begin
            slp(mode_tab[i], 1'b1);
            chk("asleep", sleeping, 1'b1);
            chk("gates", clk_gate, gate_tab[i]);
            chk("bod kept", bod_enable, 1'b1);
            wake_time(wake_tab[i], lat_tab[i]);
        end
        rd(SPC_SLEEP_CTRL_OFS, {4'h0, SPC_MODE_XSTBY, 1'b1}, "ctrl kept");
        $display("test modes done");

        // edges, memory-ready, converter, other io and a synchronous timer must not wake
        async_timer_async <= 1'b0;
        slp(SPC_MODE_PSAVE, 1'b1);
        wake_evt <= 10'h30F;
        repeat (4) @(posedge clk);
        wake_evt <= '0;
        #1;
        chk("filtered", sleeping, 1'b1);
        ext_irq_level_n <= 2'h1;
        for (int n = 0; n < 30 && irq_service !== 1'b1; n++)
            @(posedge clk) #1;
        chk("level wake", irq_service, 1'b1);
        ext_irq_level_n <= 2'h3;
        async_timer_async <= 1'b1;
        repeat (3) @(posedge clk);
        $display("test wake filter done");

        wr(SPC_CORE_CTRL_OFS, 8'h40);
        rd(SPC_CORE_CTRL_OFS, 8'h00, "unguarded write");
        wr(SPC_CORE_CTRL_OFS, 8'h60);
        repeat (5) @(posedge clk);
        wr(SPC_CORE_CTRL_OFS, 8'h40);
        rd(SPC_CORE_CTRL_OFS, 8'h00, "late write");
        wr(SPC_CORE_CTRL_OFS, 8'h60);
        wr(SPC_CORE_CTRL_OFS, 8'h40);
        rd(SPC_CORE_CTRL_OFS, 8'h40, "guarded write");
        slp(SPC_MODE_IDLE, 1'b1);
        chk("bod in idle", bod_enable, 1'b1);
        wake_time(10'h020, 7);
        wr(SPC_CORE_CTRL_OFS, 8'h60);
        wr(SPC_CORE_CTRL_OFS, 8'h40);
        slp(SPC_MODE_PDOWN, 1'b1);
        chk("bod off", bod_enable, 1'b0);
        wake_time(10'h020, SPC_BOD_WAKE_CYC + SPC_HALT_CYC);
        chk("bod back", bod_enable, 1'b1);
        rd(SPC_CORE_CTRL_OFS, 8'h00, "bit cleared");
        bod_fuse_enable <= 1'b0;
        wr(SPC_CORE_CTRL_OFS, 8'h60);
        wr(SPC_CORE_CTRL_OFS, 8'h40);
        slp(SPC_MODE_PDOWN, 1'b1);
        chk("fuse off bod", bod_enable, 1'b0);
        wake_time(10'h020, 7);
        bod_fuse_enable <= 1'b1;
        $display("test brown-out done");

        // six mode wakes, one level wake and three brown-out wakes so far
        chk("service count", services, 10);

        slp(SPC_MODE_PDOWN, 1'b1);
        #3 reset_n = 1'b0;
        #1;
        chk("reset wakes", sleeping, 1'b0);
        chk("reset gates", clk_gate, 8'hFF);
        chk("reset halt", core_halt, 1'b0);
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(SPC_SLEEP_CTRL_OFS, 8'h00, "ctrl after reset");
        chk("services", services, 0);
        $display("test reset in sleep done");
        tally_and_finish;
    end
endmodule
